// File: rtl/atc_defs.svh
// Register addresses, field positions, reset values and widths of the threshold block
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH
`define ATC_CFG_ADDR     8'h0F
`define ATC_SETL_ADDR    8'h10
`define ATC_CFG_RESET    8'h19
`define ATC_SETL_RESET   8'h00
`define ATC_CFG_FIXED    7
`define ATC_CFG_CMP_HI   6
`define ATC_CFG_CMP_LO   5
`define ATC_CFG_CH1_EN   4
`define ATC_CFG_CH2_EN   3
`define ATC_CFG_MODE_HI  2
`define ATC_SETL_RSVD    5
`define ATC_SETL_HYST    4
`define ATC_SHIFT_HI     3
`define ATC_DATA_W       16
`define ATC_FRAC_W       17
`define ATC_HYST_SHIFT   2
`endif

// File: rtl/atc_pkg.sv
// Types shared by the threshold block files
`default_nettype none
package atc_pkg;
  typedef enum logic [1:0] {
    ATC_CMP_NEG = 2'b00,
    ATC_CMP_POS = 2'b01,
    ATC_CMP_IN  = 2'b10,
    ATC_CMP_OUT = 2'b11
  } atc_cmp_mode_t;
  typedef enum logic [2:0] {
    ATC_MODE_IDLE   = 3'b000,
    ATC_MODE_CONT   = 3'b001,
    ATC_MODE_SINGLE = 3'b010
  } atc_conv_mode_t;
endpackage
`default_nettype wire

// File: rtl/atc_avg_update.sv
// Next value of one channel's running average in fixed point
`default_nettype none
module atc_avg_update #(
  parameter int DW = 16,
  parameter int FW = 17
) (
  input  wire logic [DW-1:0]    sample,
  input  wire logic [DW+FW-1:0] avg,
  input  wire logic [3:0]       shift,
  input  wire logic             init,
  output logic      [DW+FW-1:0] next_avg
);
  localparam int AW = DW + FW;
  logic signed [AW:0] diff;
  logic signed [AW:0] step;
  logic signed [AW:0] sum;
  logic        [4:0]  shift_amt;

  // Fraction bits keep small steps from being lost at long time constants
  assign shift_amt = {1'b0, shift} + 5'h01;
  assign diff      = $signed({1'b0, sample, {FW{1'b0}}}) - $signed({1'b0, avg});
  assign step      = diff >>> shift_amt;
  assign sum       = $signed({1'b0, avg}) + step;
  // First sample loads directly, so no long settle from zero
  assign next_avg  = init ? {sample, {FW{1'b0}}} : sum[AW-1:0];
endmodule
`default_nettype wire

// File: rtl/atc_compare.sv
// Detection decision for one channel, fixed or adaptive threshold
`include "atc_defs.svh"
`default_nettype none
module atc_compare #(
  parameter int DW = 16
) (
  input  wire logic                  fixed_mode,
  input  wire atc_pkg::atc_cmp_mode_t cmp_mode,
  input  wire logic                  hyst_en,
  input  wire logic                  active,
  input  wire logic [DW-1:0]         data,
  input  wire logic [DW-1:0]         avg,
  input  wire logic [DW-1:0]         sens,
  input  wire logic [DW-1:0]         thr,
  output logic                       hit
);
  logic signed [DW+2:0] ref_v;
  logic signed [DW+2:0] margin;
  logic signed [DW+2:0] band;
  logic signed [DW+2:0] lo;
  logic signed [DW+2:0] hi;
  logic signed [DW+2:0] d;
  logic                 widen;
  logic                 band_on;

  // Reference is the threshold register or the running average
  assign ref_v   = fixed_mode ? $signed({3'b000, thr}) : $signed({3'b000, avg});
  assign margin  = (fixed_mode && !cmp_mode[1]) ? '0 : $signed({3'b000, sens});
  // Dead band only in adaptive mode, holds an active output longer
  assign band_on = hyst_en && !fixed_mode && active;
  assign band    = band_on ? $signed({3'b000, sens >> `ATC_HYST_SHIFT}) : '0;
  assign widen   = (cmp_mode == atc_pkg::ATC_CMP_IN);
  assign lo      = widen ? ref_v - margin - band : ref_v - margin + band;
  assign hi      = widen ? ref_v + margin + band : ref_v + margin - band;
  assign d       = $signed({3'b000, data});

  // Comparator mode selects the sense of detection
  always_comb
  begin
    case (cmp_mode)
      atc_pkg::ATC_CMP_NEG: hit = d < lo;
      atc_pkg::ATC_CMP_POS: hit = d > hi;
      atc_pkg::ATC_CMP_IN:  hit = (d > lo) && (d < hi);
      atc_pkg::ATC_CMP_OUT: hit = (d < lo) || (d > hi);
      default:              hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// File: rtl/atc_core.sv
// Configuration registers, running averages and detection of the two-channel converter
// How it works
// - Dead-band bit ignored in fixed threshold mode.
// - Settling field bits 3:0 set averaging speed.
// - Average gains difference over two^(field+1).
// - One update per finished conversion, newest result.
// - Time constant two to 65536 conversions.
// - Configuration register 0x0F, 8 bits, preset 0x19.
// - Preset: channel enables, mode bit0 set.
// - Fixed bit set compares against threshold values.
// - Fixed bit clear compares against adaptive average.
// - Mode bits select negative, positive, window tests.
// - Mode 000 idle, 001 continuous, 010 single.
`include "atc_defs.svh"
`default_nettype none
module atc_core #(
  parameter int DW = `ATC_DATA_W,
  parameter int FW = `ATC_FRAC_W
) (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  output logic      [7:0]      reg_rdata,
  input  wire logic            conv_done,
  input  wire logic            conv_channel,
  input  wire logic [DW-1:0]   conv_data,
  input  wire logic [2*DW-1:0] sensitivity,
  input  wire logic [2*DW-1:0] fixed_threshold,
  output logic      [1:0]      detect,
  output logic      [2*DW-1:0] average,
  output logic      [1:0]      channel_enable,
  output logic                 conv_continuous,
  output logic                 conv_single_start
);
  localparam int AW = DW + FW;

  logic [7:0]    cfg;
  logic [7:0]    setl;
  logic [7:0]    next_cfg;
  logic [1:0]    pending;
  logic [1:0]    next_pending;
  logic [1:0]    avg_valid;
  logic [AW-1:0] avg_q [2];
  logic [1:0]    hit;
  logic          wr_cfg;
  logic          wr_setl;
  logic          single_cmd;
  logic          accept;
  logic          single_finish;
  logic [1:0]    ch_en;
  logic [7:0]    rd_mux;
  atc_pkg::atc_conv_mode_t mode;

  // True when the converter mode produces conversions
  function automatic logic mode_runs(input logic [2:0] m);
    case (m)
      atc_pkg::ATC_MODE_CONT:   mode_runs = 1'b1;
      atc_pkg::ATC_MODE_SINGLE: mode_runs = 1'b1;
      default:                  mode_runs = 1'b0;
    endcase
  endfunction

  // Register decode
  assign wr_cfg     = reg_wr && (reg_addr == `ATC_CFG_ADDR);
  assign wr_setl    = reg_wr && (reg_addr == `ATC_SETL_ADDR);
  assign single_cmd = wr_cfg && (reg_wdata[`ATC_CFG_MODE_HI:0] == atc_pkg::ATC_MODE_SINGLE);
  assign mode       = atc_pkg::atc_conv_mode_t'(cfg[`ATC_CFG_MODE_HI:0]);
  assign ch_en      = {cfg[`ATC_CFG_CH2_EN], cfg[`ATC_CFG_CH1_EN]};
  assign rd_mux     = (reg_addr == `ATC_CFG_ADDR)  ? cfg :
                      (reg_addr == `ATC_SETL_ADDR) ? setl : 8'h00;

  // Only results of enabled channels in a converting mode count
  assign accept = conv_done && mode_runs(mode) && ch_en[conv_channel] &&
                  ((mode == atc_pkg::ATC_MODE_CONT) || pending[conv_channel]);

  // Single run ends once every armed channel has delivered
  assign single_finish = (mode == atc_pkg::ATC_MODE_SINGLE) && (pending != 2'b00) &&
                         (next_pending == 2'b00);
  assign next_pending  = single_cmd ? reg_wdata[`ATC_CFG_CH1_EN -: 2] == 2'b00 ? 2'b00 :
                         {reg_wdata[`ATC_CFG_CH2_EN], reg_wdata[`ATC_CFG_CH1_EN]} :
                         accept ? pending & ~(2'b01 << conv_channel) : pending;
  // A new software command outranks the return to idle
  assign next_cfg = wr_cfg ? reg_wdata :
                    single_finish ? {cfg[7:3], atc_pkg::ATC_MODE_IDLE} : cfg;

  // Configuration and settling registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cfg     <= `ATC_CFG_RESET;
      setl    <= `ATC_SETL_RESET;
      pending <= 2'b00;
    end
    else
    begin
      cfg     <= next_cfg;
      pending <= next_pending;
      if (wr_setl)
        setl <= reg_wdata;
    end
  end

  // Read data held until the next read
  always_ff @(posedge clk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end

  // Converter control outputs
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      conv_continuous   <= 1'b0;
      conv_single_start <= 1'b0;
      channel_enable    <= 2'b00;
    end
    else
    begin
      conv_continuous   <= next_cfg[`ATC_CFG_MODE_HI:0] == atc_pkg::ATC_MODE_CONT;
      conv_single_start <= single_cmd;
      channel_enable    <= {next_cfg[`ATC_CFG_CH2_EN], next_cfg[`ATC_CFG_CH1_EN]};
    end
  end

  // Per-channel average and detection
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      logic [AW-1:0] next_avg;
      logic [DW-1:0] avg_ref;
      logic          take;

      assign take    = accept && (conv_channel == ch);
      // Before the first result the sample itself stands in for the average
      assign avg_ref = avg_valid[ch] ? avg_q[ch][AW-1:FW] : conv_data;

      atc_avg_update #(
        .DW (DW),
        .FW (FW)
      ) u_avg (
        .sample   (conv_data),
        .avg      (avg_q[ch]),
        .shift    (setl[`ATC_SHIFT_HI:0]),
        .init     (!avg_valid[ch]),
        .next_avg (next_avg)
      );

      atc_compare #(
        .DW (DW)
      ) u_cmp (
        .fixed_mode (cfg[`ATC_CFG_FIXED]),
        .cmp_mode   (atc_pkg::atc_cmp_mode_t'(cfg[`ATC_CFG_CMP_HI:`ATC_CFG_CMP_LO])),
        .hyst_en    (setl[`ATC_SETL_HYST]),
        .active     (detect[ch]),
        .data       (conv_data),
        .avg        (avg_ref),
        .sens       (sensitivity[ch*DW +: DW]),
        .thr        (fixed_threshold[ch*DW +: DW]),
        .hit        (hit[ch])
      );

      // Any configuration write restarts averaging from the next result
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          avg_q[ch]     <= '0;
          avg_valid[ch] <= 1'b0;
          detect[ch]    <= 1'b0;
        end
        else
        begin
          if (take)
          begin
            avg_q[ch]  <= next_avg;
            detect[ch] <= hit[ch];
          end
          if (wr_cfg)
            avg_valid[ch] <= 1'b0;
          else if (take)
            avg_valid[ch] <= 1'b1;
        end
      end

      assign average[ch*DW +: DW] = avg_q[ch][AW-1:FW];
    end
  endgenerate

  // Checks on register, averaging and detection behaviour
  logic [AW-1:0] data_ext;
  logic          take0;
  logic [DW+1:0] pos_hi0;
  logic [DW+1:0] neg_sum0;
  logic [DW+1:0] avg_int0;
  logic [1:0]    wr_ch_en;
  logic          last_single;
  assign data_ext = {conv_data, {FW{1'b0}}};
  assign take0    = accept && !conv_channel;
  assign pos_hi0  = {2'b00, avg_q[0][AW-1:FW]} + {2'b00, sensitivity[DW-1:0]};
  // Negative test as data plus margin below average, so nothing wraps
  assign neg_sum0 = {2'b00, conv_data} + {2'b00, sensitivity[DW-1:0]};
  assign avg_int0 = {2'b00, avg_q[0][AW-1:FW]};
  assign wr_ch_en = {reg_wdata[`ATC_CFG_CH2_EN], reg_wdata[`ATC_CFG_CH1_EN]};
  // Result that ends a single run: last channel owed, no write racing it
  assign last_single = conv_done && ch_en[conv_channel] && !wr_cfg &&
                       (pending == (2'b01 << conv_channel));

  // Steps of a single run: command, armed pulse, last result, idle
  sequence s_single_cmd;
    wr_cfg && (reg_wdata[2:0] == 3'b010) && (reg_wdata[4:3] != 2'b00);
  endsequence
  sequence s_single_armed;
    conv_single_start && (cfg[2:0] == 3'b010) && (pending != 2'b00);
  endsequence
  sequence s_last_single;
    (cfg[2:0] == 3'b010) && last_single;
  endsequence
  sequence s_back_idle;
    (cfg[2:0] == 3'b000) && !conv_continuous && (pending == 2'b00);
  endsequence

  // Register port
  // Preset must hold at the first edge after release unless a write lands there
  a_cfg_preset: assert property (@(posedge clk) disable iff (!resetn)
    !$past(resetn) && !$past(wr_cfg) |-> cfg == 8'h19)
    else $error("configuration preset wrong");
  a_cfg_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_cfg |=> cfg == $past(reg_wdata))
    else $error("configuration write lost");
  a_cfg_read: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && !reg_wr && reg_addr == 8'h0F |=> reg_rdata == $past(cfg))
    else $error("configuration read wrong");
  a_setl_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_setl |=> setl == $past(reg_wdata))
    else $error("settling write lost");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && reg_addr != `ATC_CFG_ADDR && reg_addr != `ATC_SETL_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ch_enable: assert property (@(posedge clk) disable iff (!resetn)
    wr_cfg |=> channel_enable == $past(wr_ch_en))
    else $error("channel enables not following configuration");

  // Running average; helpers take0, pos_hi0, neg_sum0 and avg_int0 above watch channel one only
  a_avg_first: assert property (@(posedge clk) disable iff (!resetn)
    take0 && !avg_valid[0] |=> average[DW-1:0] == $past(conv_data))
    else $error("average not seeded by first result");
  a_ch2_seed: assert property (@(posedge clk) disable iff (!resetn)
    accept && conv_channel && !avg_valid[1] |=> average[2*DW-1:DW] == $past(conv_data))
    else $error("second channel average not seeded");
  a_avg_toward: assert property (@(posedge clk) disable iff (!resetn)
    take0 && avg_valid[0] && data_ext >= avg_q[0]
    |=> avg_q[0] >= $past(avg_q[0]) && avg_q[0] <= $past(data_ext))
    else $error("average moved away from data");
  // Floor rounding of a negative step always moves down by one or more
  a_avg_down: assert property (@(posedge clk) disable iff (!resetn)
    take0 && avg_valid[0] && data_ext < avg_q[0]
    |=> avg_q[0] < $past(avg_q[0]) && avg_q[0] >= $past(data_ext))
    else $error("average moved away from lower data");
  a_avg_idle: assert property (@(posedge clk) disable iff (!resetn)
    !take0 |=> $stable(avg_q[0]) && $stable(detect[0]))
    else $error("average changed without accepted result");

  // Detection, fixed and adaptive
  a_fixed_pos: assert property (@(posedge clk) disable iff (!resetn)
    take0 && cfg[7:5] == 3'b101 && conv_data > fixed_threshold[DW-1:0]
    |=> detect[0])
    else $error("fixed positive detection missed");
  a_fixed_band: assert property (@(posedge clk) disable iff (!resetn)
    take0 && cfg[7:5] == 3'b101 && conv_data <= fixed_threshold[DW-1:0]
    |=> !detect[0])
    else $error("dead band applied in fixed mode");
  a_adapt_pos: assert property (@(posedge clk) disable iff (!resetn)
    take0 && avg_valid[0] && cfg[7:5] == 3'b001 && {2'b00, conv_data} > pos_hi0
    |=> detect[0])
    else $error("adaptive positive detection missed");
  a_adapt_neg: assert property (@(posedge clk) disable iff (!resetn)
    take0 && avg_valid[0] && cfg[7:5] == 3'b000 && neg_sum0 < avg_int0
    |=> detect[0])
    else $error("adaptive negative detection missed");

  // Converter modes
  a_single_start: assert property (@(posedge clk) disable iff (!resetn)
    s_single_cmd |=> s_single_armed)
    else $error("single conversion not armed");
  a_single_end: assert property (@(posedge clk) disable iff (!resetn)
    s_last_single |=> s_back_idle)
    else $error("single run did not return to idle");
  a_cont_flag: assert property (@(posedge clk) disable iff (!resetn)
    wr_cfg && reg_wdata[2:0] == 3'b001 |=> conv_continuous && !conv_single_start)
    else $error("continuous mode not flagged");
  // Idle must not touch results, even on a late strobe from the converter
  a_idle_hold: assert property (@(posedge clk) disable iff (!resetn)
    cfg[2:0] == 3'b000 |=> $stable(average) && $stable(detect))
    else $error("idle mode changed results");
endmodule
`default_nettype wire

// File: sim/atc_conv_model.sv
// Converter result source standing at the far side of the threshold block
`default_nettype none
module atc_conv_model (
  input  wire logic        clk,
  output var logic         conv_done,
  output var logic         conv_channel,
  output var logic  [15:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet lines at start
  initial
  begin
    conv_done    = 1'b0;
    conv_channel = 1'b0;
    conv_data    = 16'h0000;
  end

  // One result strobe after an idle gap; lines invert afterwards so no stale sample lingers
  task automatic send(input logic ch, input logic [15:0] d, input int gap);
    repeat (gap) @(posedge clk);
    conv_done    <= 1'b1;
    conv_channel <= ch;
    conv_data    <= d;
    @(posedge clk);
    conv_done    <= 1'b0;
    conv_channel <= ~ch;
    conv_data    <= ~d;
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench: registers, averaging, detection and converter modes
`include "atc_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        resetn;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        conv_done;
  logic        conv_channel;
  logic [15:0] conv_data;
  logic [31:0] sensitivity;
  logic [31:0] fixed_threshold;
  logic [1:0]  detect;
  logic [31:0] average;
  logic [1:0]  channel_enable;
  logic        conv_continuous;
  logic        conv_single_start;
  logic [7:0]  v;
  int          failures;
  int          samples_checked;
  // Expected detect per comparator mode, bit index is the mode code
  logic [3:0]  exp_first  = 4'h4;
  logic [3:0]  exp_second = 4'hA;
  logic [3:0]  exp_third  = 4'h9;

  atc_core u_dut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .conv_channel(conv_channel), .conv_data(conv_data),
    .sensitivity(sensitivity), .fixed_threshold(fixed_threshold), .detect(detect),
    .average(average), .channel_enable(channel_enable),
    .conv_continuous(conv_continuous), .conv_single_start(conv_single_start));
  atc_conv_model u_conv (.clk(clk), .conv_done(conv_done), .conv_channel(conv_channel),
    .conv_data(conv_data));

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Extra edge before looking, since outputs stand until the next accepted result
  task automatic res(input logic ch, input logic [15:0] d, input int gap);
    u_conv.send(ch, d, gap);
    @(posedge clk);
    #1;
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog so a hang still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  // Main sequence
  initial
  begin
    failures        = 0;
    samples_checked = 0;
    resetn          = 1'b0;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    sensitivity     = 32'h0000_0032;
    fixed_threshold = 32'h0000_1388;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(`ATC_CFG_ADDR, v);
    chk("cfg preset", v, 8'h19);
    rd(`ATC_SETL_ADDR, v);
    chk("settling preset", v, 8'h00);
    rd(8'h3C, v);
    chk("unmapped read", v, 8'h00);
    chk("chan enables", channel_enable, 2'h3);
    chk("continuous", conv_continuous, 1'h1);
    // Seed, then shift zero halves the step
    res(1'b0, 16'h03E8, 1);
    chk("avg seed", average[15:0], 16'h03E8);
    res(1'b0, 16'h07D0, 1);
    chk("avg half", average[15:0], 16'h05DC);
    wr(`ATC_SETL_ADDR, 8'h03); // bit five kept clear
    res(1'b0, 16'h0C1C, 1);
    chk("avg shift3", average[15:0], 16'h0640);
    // Longest time constant: two full-scale steps move the integer part by one
    wr(`ATC_SETL_ADDR, 8'h0F);
    res(1'b0, 16'hFFFF, 1);
    res(1'b0, 16'hFFFF, 1);
    chk("avg shift15", average[15:0], 16'h0641);
    wr(`ATC_SETL_ADDR, 8'h00);
    // Every comparator mode in adaptive thresholds
    for (int m = 0; m < 4; m++)
    begin
      wr(`ATC_CFG_ADDR, {1'b0, m[1:0], 5'h19});
      res(1'b0, 16'h1000, 1);
      chk("det first", detect[0], exp_first[m]);
      res(1'b0, 16'h1064, 1);
      chk("det second", detect[0], exp_second[m]);
      res(1'b0, 16'h0F9C, 1);
      chk("det third", detect[0], exp_third[m]);
    end
    // Fixed threshold, positive mode, dead band off then on
    wr(`ATC_CFG_ADDR, 8'hB9);
    res(1'b0, 16'h1389, 1);
    chk("fixed above", detect[0], 1'h1);
    res(1'b0, 16'h1387, 1);
    chk("fixed below", detect[0], 1'h0);
    wr(`ATC_SETL_ADDR, 8'h10);
    res(1'b0, 16'h1389, 1);
    chk("fixed hyst above", detect[0], 1'h1);
    res(1'b0, 16'h1388, 1);
    chk("fixed hyst equal", detect[0], 1'h0);
    // Adaptive positive with dead band: an active output holds inside the narrowed margin
    wr(`ATC_CFG_ADDR, 8'h39);
    res(1'b0, 16'h1000, 1);
    res(1'b0, 16'h1064, 1);
    chk("adapt hyst set", detect[0], 1'h1);
    res(1'b0, 16'h105E, 1);
    chk("adapt hyst hold", detect[0], 1'h1);
    // Channel two disabled: its results are dropped
    wr(`ATC_CFG_ADDR, 8'h11);
    chk("chan enables", channel_enable, 2'h1);
    res(1'b1, 16'h02BC, 1);
    chk("ch2 dropped", average[31:16], 16'h0000);
    // Single conversion over both channels, slow then prompt
    wr(`ATC_CFG_ADDR, 8'h1A);
    chk("single pulse", conv_single_start, 1'h1);
    chk("not continuous", conv_continuous, 1'h0);
    @(posedge clk);
    #1;
    chk("single pulse end", conv_single_start, 1'h0);
    res(1'b1, 16'h02BC, 5);
    chk("ch2 seed", average[31:16], 16'h02BC);
    chk("ch2 detect", detect[1], 1'h0);
    res(1'b0, 16'h0100, 1);
    chk("ch1 seed", average[15:0], 16'h0100);
    rd(`ATC_CFG_ADDR, v);
    chk("back to idle", v, 8'h18);
    res(1'b0, 16'h0200, 1);
    chk("idle dropped", average[15:0], 16'h0100);
    close_out();
  end
endmodule
`default_nettype wire
